// *** include/pfh_pkg.sv ***
// Package for the parallel flash host controller: pin timing and widths.
// Assumes a single 20 MHz system clock; times are given in nanoseconds.
package pfh_pkg;
	// ----------------------------------------------------------------
	// Clock
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS        = 50;          // 20 MHz period
	// ----------------------------------------------------------------
	// Timing (plain defaults, no figure is given for these)
	// ----------------------------------------------------------------
	localparam int unsigned RESET_PULSE_MIN_NS   = 500;         // Least reset low time
	localparam int unsigned RESET_TO_ENABLE_NS   = 50;          // Least release-to-access
	localparam int unsigned READY_TO_ENABLE_NS   = 0;           // Least ready-to-access
	localparam int unsigned ACCESS_NS            = 100;         // Read access wait
	localparam int unsigned WRITE_PULSE_NS       = 100;         // Write strobe low time
	localparam int unsigned SETUP_NS             = 50;          // Setup and hold margin
	// Rounded-up cycle counts, at least one
	function automatic int unsigned pfh_cyc(input int unsigned ns);
		int unsigned c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c == 0) ? 1 : c;
	endfunction
	localparam int unsigned RESET_PULSE_CYC      = pfh_cyc(RESET_PULSE_MIN_NS);
	localparam int unsigned RESET_TO_ENABLE_CYC  = pfh_cyc(RESET_TO_ENABLE_NS);
	localparam int unsigned READY_TO_ENABLE_CYC  = pfh_cyc(READY_TO_ENABLE_NS);
	localparam int unsigned ACCESS_CYC           = pfh_cyc(ACCESS_NS);
	localparam int unsigned WRITE_PULSE_CYC      = pfh_cyc(WRITE_PULSE_NS);
	localparam int unsigned SETUP_CYC            = pfh_cyc(SETUP_NS);
	localparam int unsigned CNT_W                = 8;           // Timer width
	// ----------------------------------------------------------------
	// Bus widths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W               = 17;          // addr_inputs width
	localparam int unsigned HADDR_W              = 18;          // Byte address width
	localparam int unsigned DATA_W               = 16;          // Word width
	localparam int unsigned LOW_W                = 8;           // data_low_lane width
	localparam int unsigned HIGH_W               = 7;           // data_high_lane width
	localparam int unsigned D15_BIT              = 15;          // Shared bit position
endpackage

// *** include/pfh_rb_if.sv ***
// Interface carrying the synchronised ready line to the pin timer.
// Assumes both ends run on sys_clk_i.
`timescale 1ns/1ps
interface pfh_rb_if;
	logic ready;     // Line released (high), synchronised
	logic reset_req; // Pulse: start hardware reset
	logic reset_busy;// Reset sequence in progress
	modport ctrl (input ready, input reset_busy, output reset_req);
	modport seq  (output ready, output reset_busy, input reset_req);
endinterface

// *** hdl/pfh_reset_seq.sv ***
// Reset sequencer: synchronises ready_busy_n and times the reset pulse.
// Assumes the flash ready line has an external pull-up.
`timescale 1ns/1ps
module pfh_reset_seq (
	input  wire logic sys_clk_i,   // System clock
	input  wire logic rst_n_i,     // Async reset, active low
	input  wire logic rb_pin_i,    // ready_busy_n pin level
	output logic      rp_n_o,      // reset_unprotect_n drive
	pfh_rb_if.seq     rb           // Towards controller
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PFH_RS_IDLE  = 3'b001, // No reset in progress
		PFH_RS_PULSE = 3'b010, // Pin held low
		PFH_RS_WAIT  = 3'b100  // Waiting for release and ready
	} pfh_rs_t;
	pfh_rs_t                     st_q, st_d;     // Sequencer state
	logic [pfh_pkg::CNT_W-1:0]   cnt_q, cnt_d;   // Timer
	logic                        s1_q, s2_q;     // Ready synchroniser
	logic                        rp_q, rp_d;     // Reset pin register
	// Two-stage pin synchroniser
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else begin
			s1_q <= rb_pin_i;
			s2_q <= s1_q;
		end
	end
	assign rb.ready      = s2_q;                      // Low: some device busy
	assign rb.reset_busy = (st_q != PFH_RS_IDLE);
	assign rp_n_o        = rp_q;
	// Next state
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		rp_d  = rp_q;
		unique case (st_q)
			PFH_RS_IDLE: begin
				if (rb.reset_req) begin
					st_d  = PFH_RS_PULSE;
					rp_d  = 1'b0;
					cnt_d = pfh_pkg::CNT_W'(pfh_pkg::RESET_PULSE_CYC);
				end
			end
			PFH_RS_PULSE: begin
				// Hold low at least the least pulse time
				if (cnt_q > pfh_pkg::CNT_W'(1)) begin
					cnt_d = cnt_q - pfh_pkg::CNT_W'(1);
				end else begin
					rp_d  = 1'b1;
					st_d  = PFH_RS_WAIT;
					cnt_d = pfh_pkg::CNT_W'((pfh_pkg::RESET_TO_ENABLE_CYC > pfh_pkg::READY_TO_ENABLE_CYC)
						? pfh_pkg::RESET_TO_ENABLE_CYC : pfh_pkg::READY_TO_ENABLE_CYC);
				end
			end
			PFH_RS_WAIT: begin
				// Later of both delays, and ready seen released
				if (cnt_q != '0) begin
					cnt_d = cnt_q - pfh_pkg::CNT_W'(1);
				end else if (s2_q) begin
					st_d = PFH_RS_IDLE;
				end
			end
			default: st_d = PFH_RS_IDLE;
		endcase
	end
	// Registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q  <= PFH_RS_IDLE;
			cnt_q <= '0;
			rp_q  <= 1'b1;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			rp_q  <= rp_d;
		end
	end
endmodule

// *** hdl/pfh_host.sv ***
// Host controller that drives an asynchronous parallel flash over its pins.
// Assumes pull-ups on ready_busy_n and a single clock domain.
// Notes on behaviour
// - Host ignores high lane on status
// - Reset pulse least time, then enable delays
// - Host waits ready release after reset
// - Shared low ready means some busy
// - Address latched last fall, data first rise
// - Read with output enable, write without
`timescale 1ns/1ps
module pfh_host (
	input  wire logic                         sys_clk_i,        // System clock
	input  wire logic                         rst_n_i,          // Async reset, active low
	// User side
	input  wire logic                         req_i,            // Access request level
	input  wire logic                         we_i,             // 1 write, 0 read
	input  wire logic                         byte_mode_i,      // 1 selects 8-bit bus
	input  wire logic                         status_i,         // Read is a status read
	input  wire logic [pfh_pkg::HADDR_W-1:0]  addr_i,           // Byte or word address
	input  wire logic [pfh_pkg::DATA_W-1:0]   wdata_i,          // Write data
	input  wire logic                         hw_reset_i,       // Request hardware reset
	output logic                              ack_o,            // Pulse: access done
	output logic [pfh_pkg::DATA_W-1:0]        rdata_o,          // Read data
	output logic                              busy_o,           // Controller not idle
	output logic                              flash_ready_o,    // Ready line released
	// Flash pins
	output logic [pfh_pkg::ADDR_W-1:0]        addr_inputs_o,    // Address pins
	output logic                              chip_select_n_o,  // Chip select
	output logic                              output_enable_n_o,// Output enable
	output logic                              write_strobe_n_o, // Write strobe
	output logic                              bus_width_select_o,// 1 word, 0 byte
	output logic                              reset_unprotect_n_o,// Reset pin
	input  wire logic [pfh_pkg::LOW_W-1:0]    data_low_lane_i,  // Low lane in
	output logic [pfh_pkg::LOW_W-1:0]         data_low_lane_o,  // Low lane out
	output logic                              data_low_lane_oe_n_o,// Low lane enable, low drives
	input  wire logic [pfh_pkg::HIGH_W-1:0]   data_high_lane_i, // High lane in
	output logic [pfh_pkg::HIGH_W-1:0]        data_high_lane_o, // High lane out
	output logic                              data_high_lane_oe_n_o,// High lane enable, low drives
	input  wire logic                         data15_or_addr_lsb_i,// Shared pin in
	output logic                              data15_or_addr_lsb_o,// Shared pin out
	output logic                              data15_or_addr_lsb_oe_n_o,// Shared enable, low drives
	input  wire logic                         ready_busy_n_i    // Ready line level
);
	// ----------------------------------------------------------------
	// Reset sequencer
	// ----------------------------------------------------------------
	pfh_rb_if rb ();                                           // Ready and reset link
	pfh_reset_seq u_seq (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.rb_pin_i  (ready_busy_n_i),
		.rp_n_o    (reset_unprotect_n_o),
		.rb        (rb)
	);
	// ----------------------------------------------------------------
	// Data pin synchroniser (read data is async to the clock)
	// ----------------------------------------------------------------
	logic [pfh_pkg::DATA_W-1:0] dsy1_q, dsy2_q;                // Two stages
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dsy1_q <= '0;
			dsy2_q <= '0;
		end else begin
			dsy1_q <= {data15_or_addr_lsb_i, data_high_lane_i, data_low_lane_i};
			dsy2_q <= dsy1_q;
		end
	end
	// ----------------------------------------------------------------
	// Access state machine
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		PFH_IDLE  = 6'b000001, // Waiting for request
		PFH_SETUP = 6'b000010, // Address stable, strobes high
		PFH_STRB  = 6'b000100, // Strobe asserted
		PFH_HOLD  = 6'b001000, // Strobe released, hold
		PFH_SAMP  = 6'b010000, // Data through synchroniser
		PFH_RST   = 6'b100000  // Hardware reset running
	} pfh_st_t;
	pfh_st_t                    st_q, st_d;                    // State
	logic [pfh_pkg::CNT_W-1:0]  cnt_q, cnt_d;                  // Timer
	logic                       we_q, we_d;                    // Access is write
	logic                       bm_q, bm_d;                    // Byte mode latched
	logic                       stat_q, stat_d;                // Status read
	logic                       lsb_q, lsb_d;                  // Byte select bit
	logic [pfh_pkg::ADDR_W-1:0] addr_q, addr_d;                // Address pins
	logic [pfh_pkg::DATA_W-1:0] wd_q, wd_d;                    // Write data
	logic [pfh_pkg::DATA_W-1:0] rd_q, rd_d;                    // Read data
	logic                       cs_q, cs_d;                    // Chip select, low active
	logic                       oe_q, oe_d;                    // Output enable, low active
	logic                       ws_q, ws_d;                    // Write strobe, low active
	logic                       drv_q, drv_d;                  // Driving data pins
	logic                       ack_q, ack_d;                  // Done pulse
	logic                       rreq_q, rreq_d;                // Reset request pulse
	// Counter load helper
	function automatic logic [pfh_pkg::CNT_W-1:0] pfh_ld(input int unsigned c);
		return pfh_pkg::CNT_W'(c);
	endfunction
	// Next state
	always_comb begin
		st_d = st_q; cnt_d = cnt_q; we_d = we_q; bm_d = bm_q; stat_d = stat_q;
		lsb_d = lsb_q; addr_d = addr_q; wd_d = wd_q; rd_d = rd_q;
		cs_d = cs_q; oe_d = oe_q; ws_d = ws_q; drv_d = drv_q;
		ack_d = 1'b0; rreq_d = 1'b0;
		unique case (st_q)
			PFH_IDLE: begin
				if (hw_reset_i) begin
					rreq_d = 1'b1;                            // Start reset pulse
					st_d   = PFH_RST;
				end else if (req_i && rb.ready) begin         // Only when released
					we_d = we_i; bm_d = byte_mode_i; stat_d = status_i; wd_d = wdata_i;
					if (byte_mode_i) begin
						addr_d = addr_i[pfh_pkg::HADDR_W-1:1];   // Word part
						lsb_d  = addr_i[0];                      // Byte select
					end else begin
						addr_d = addr_i[pfh_pkg::ADDR_W-1:0];
						lsb_d  = 1'b0;
					end
					cs_d  = 1'b1; oe_d = 1'b1; ws_d = 1'b1;     // Strobes high during setup
					drv_d = we_i;
					cnt_d = pfh_ld(pfh_pkg::SETUP_CYC);
					st_d  = PFH_SETUP;
				end
			end
			PFH_SETUP: begin
				if (cnt_q > pfh_ld(1)) begin
					cnt_d = cnt_q - pfh_ld(1);
				end else begin
					cs_d = 1'b0;                               // Select device
					if (we_q) begin
						ws_d = 1'b0;                           // Address latched here
						oe_d = 1'b1;                           // Output enable high
						cnt_d = pfh_ld(pfh_pkg::WRITE_PULSE_CYC);
					end else begin
						oe_d = 1'b0;                           // Read strobes
						cnt_d = pfh_ld(pfh_pkg::ACCESS_CYC);
					end
					st_d = PFH_STRB;
				end
			end
			PFH_STRB: begin
				if (cnt_q > pfh_ld(1)) begin
					cnt_d = cnt_q - pfh_ld(1);
				end else begin
					ws_d = 1'b1;                               // Data latched on rise
					cnt_d = pfh_ld(pfh_pkg::SETUP_CYC);
					st_d  = we_q ? PFH_HOLD : PFH_SAMP;
				end
			end
			PFH_SAMP: begin
				// Let pins settle through the synchroniser before sampling
				if (cnt_q > pfh_ld(1)) begin
					cnt_d = cnt_q - pfh_ld(1);
				end else begin
					if (bm_q || stat_q) begin
						rd_d = {8'h00, dsy2_q[pfh_pkg::LOW_W-1:0]}; // High lane ignored
					end else begin
						rd_d = dsy2_q;
					end
					oe_d = 1'b1;
					cs_d = 1'b1;
					cnt_d = pfh_ld(pfh_pkg::SETUP_CYC);
					st_d  = PFH_HOLD;
				end
			end
			PFH_HOLD: begin
				cs_d = 1'b1;
				if (cnt_q > pfh_ld(1)) begin
					cnt_d = cnt_q - pfh_ld(1);
				end else begin
					drv_d = 1'b0;
					ack_d = 1'b1;
					st_d  = PFH_IDLE;
				end
			end
			PFH_RST: begin
				if (!rb.reset_busy && !rreq_q) begin
					st_d = PFH_IDLE;                           // Released and timed
				end
			end
			default: st_d = PFH_IDLE;
		endcase
	end
	// Registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= PFH_IDLE; cnt_q <= '0; we_q <= 1'b0; bm_q <= 1'b0; stat_q <= 1'b0;
			lsb_q <= 1'b0; addr_q <= '0; wd_q <= '0; rd_q <= '0;
			cs_q <= 1'b1; oe_q <= 1'b1; ws_q <= 1'b1; drv_q <= 1'b0;
			ack_q <= 1'b0; rreq_q <= 1'b0;
		end else begin
			st_q <= st_d; cnt_q <= cnt_d; we_q <= we_d; bm_q <= bm_d; stat_q <= stat_d;
			lsb_q <= lsb_d; addr_q <= addr_d; wd_q <= wd_d; rd_q <= rd_d;
			cs_q <= cs_d; oe_q <= oe_d; ws_q <= ws_d; drv_q <= drv_d;
			ack_q <= ack_d; rreq_q <= rreq_d;
		end
	end
	// ----------------------------------------------------------------
	// Pin mapping and status
	// ----------------------------------------------------------------
	logic busy_q;                                              // Not idle
	logic frdy_q;                                              // Ready copy
	logic wsel_q;                                              // Width select pin
	logic lo_oen_q;                                            // Low lane enable, low drives
	logic hi_oen_q;                                            // High lane enable, low drives
	logic p15_q;                                               // Shared pin value
	logic p15_oen_q;                                           // Shared pin enable, low drives
	// Pin drives registered from next values, so each pin leaves a flop
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_q    <= 1'b0;
			frdy_q    <= 1'b0;
			wsel_q    <= 1'b1;
			lo_oen_q  <= 1'b1;
			hi_oen_q  <= 1'b1;
			p15_q     <= 1'b0;
			p15_oen_q <= 1'b1;
		end else begin
			busy_q    <= (st_d != PFH_IDLE);
			frdy_q    <= rb.ready;
			wsel_q    <= !bm_d;
			lo_oen_q  <= !drv_d;
			hi_oen_q  <= !(drv_d && !bm_d);
			p15_q     <= bm_d ? lsb_d : wd_d[pfh_pkg::D15_BIT];
			p15_oen_q <= !(bm_d || drv_d);
		end
	end
	assign rb.reset_req               = rreq_q;
	assign ack_o                      = ack_q;
	assign rdata_o                    = rd_q;
	assign busy_o                     = busy_q;
	assign flash_ready_o              = frdy_q;
	assign addr_inputs_o              = addr_q;                   // Cell or command address
	assign chip_select_n_o            = cs_q;
	assign output_enable_n_o          = oe_q;
	assign write_strobe_n_o           = ws_q;
	assign bus_width_select_o         = wsel_q;                   // Low selects 8-bit
	assign data_low_lane_o            = wd_q[pfh_pkg::LOW_W-1:0];
	assign data_low_lane_oe_n_o       = lo_oen_q;
	assign data_high_lane_o           = wd_q[pfh_pkg::D15_BIT-1:pfh_pkg::LOW_W];
	assign data_high_lane_oe_n_o      = hi_oen_q;                 // Not driven in byte mode
	assign data15_or_addr_lsb_o       = p15_q;                    // Byte select or bit 15
	assign data15_or_addr_lsb_oe_n_o  = p15_oen_q;
endmodule

// *** test/pfh_flash_model.sv ***
// Behavioural flash seen at its pins, answering the host under test.
// Assumes the bench resolves shared lanes and pulls the ready line up.
`timescale 1ns/1ps
module pfh_flash_model #(
	parameter int unsigned PROG_NS = 400, // Busy after a write
	parameter int unsigned REC_NS  = 200,   // Busy after reset release
	parameter logic [6:0]  PROT    = 7'h00, // Protected blocks, one bit each
	parameter bit          HV      = 1'b0   // Reset pin at high_voltage_level
) (
	input  wire logic        cs_n_i,  // Chip select
	input  wire logic        oe_n_i,  // Output enable
	input  wire logic        ws_n_i,  // Write strobe
	input  wire logic        word_i,  // Word bus
	input  wire logic        rp_n_i,  // Reset pin
	input  wire logic [16:0] addr_i,  // Address pins
	input  wire logic [15:0] d_i,     // Resolved data pins
	output logic      [15:0] d_o,     // Read data
	output logic             lo_oe_o, // Drives low lane
	output logic             hi_oe_o, // Drives upper pins
	output logic             rb_low_o // Pulls ready low
);
	logic [15:0] mem [0:131071]; // One word a cell
	logic [17:0] wa;             // Latched byte address
	logic        wact = 1'b0;    // Write cycle open
	// Seven blocks: three of 64 KB, the top 64 KB split in four
	function automatic int blk(input logic [16:0] w);
		if (w[16:15] != 2'b11) return int'(w[16:15]);
		if (!w[14]) return 3;
		if (!w[13]) return w[12] ? 5 : 4;
		return 6;
	endfunction
	// Erased array, read mode, ready released
	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		rb_low_o = 1'b0;
	end
	// Drive only on a selected read
	assign lo_oe_o = !cs_n_i && !oe_n_i && ws_n_i && rp_n_i;
	assign hi_oe_o = lo_oe_o && word_i;
	// Byte mode: the shared pin picks the half
	assign d_o = word_i ? mem[addr_i] : {8'h00, d_i[15] ? mem[addr_i][15:8] : mem[addr_i][7:0]};
	// Address on the later falling edge
	always @(negedge cs_n_i or negedge ws_n_i) begin
		if (!cs_n_i && !ws_n_i && rp_n_i) begin
			wa = {addr_i, d_i[15]};
			wact = 1'b1;
		end
	end
	// Data on the earlier rising edge, then busy while storing
	always @(posedge cs_n_i or posedge ws_n_i) begin
		if (wact) begin
			wact = 1'b0;
			if (HV || !PROT[blk(wa[17:1])]) begin // Protected blocks refuse
				if (word_i) mem[wa[17:1]] = d_i;
				else if (wa[0]) mem[wa[17:1]][15:8] = d_i[7:0];
				else mem[wa[17:1]][7:0] = d_i[7:0];
			end
			rb_low_o = 1'b1; // Ready pulled low while storing
			#(PROG_NS);
			rb_low_o = !rp_n_i;
		end
	end
	// Busy through reset and its recovery
	always @(rp_n_i) begin
		if (!rp_n_i) rb_low_o = 1'b1;
		else begin
			#(REC_NS);
			rb_low_o = 1'b0;
		end
	end
endmodule

// *** test/pfh_host_chk.sv ***
// Checker of the flash host pin sequences, bound to pfh_host.
// Assumes one clock domain and the access walks of the controller.
`timescale 1ns/1ps
module pfh_host_chk (
	input wire logic sys_clk_i,                 // Clock
	input wire logic rst_n_i,                   // Reset
	input wire logic ack_o,                     // Done
	input wire logic chip_select_n_o,           // Select
	input wire logic output_enable_n_o,         // Read enable
	input wire logic write_strobe_n_o,          // Write strobe
	input wire logic bus_width_select_o,        // Width
	input wire logic reset_unprotect_n_o,       // Reset pin
	input wire logic data_low_lane_oe_n_o,      // Low enable
	input wire logic data_high_lane_oe_n_o,     // High enable
	input wire logic data15_or_addr_lsb_oe_n_o, // Shared enable
	input wire logic ready_busy_n_i             // Ready line
);
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] lo_q, lo_d; // Reset pin low cycles
	logic       wt_q, wt_d; // Reset given, ready not back
	// Next values
	always_comb begin
		lo_d = reset_unprotect_n_o ? 8'h00 : lo_q + 8'h01;
		wt_d = !reset_unprotect_n_o || (wt_q && !ready_busy_n_i);
	end
	// Registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lo_q <= 8'h00;
			wt_q <= 1'b0;
		end else begin
			lo_q <= lo_d;
			wt_q <= wt_d;
		end
	end
	// Strobe low two cycles under select, then high
	sequence wr_s;
		(!write_strobe_n_o && !chip_select_n_o)[*2] ##1 (write_strobe_n_o && !chip_select_n_o);
	endsequence
	// Select released together with done
	sequence close_s;
		chip_select_n_o && ack_o;
	endsequence
	// Read enable three cycles
	sequence rd_s;
		(!output_enable_n_o && !chip_select_n_o && write_strobe_n_o)[*3];
	endsequence
	rd_strobe_a: assert property (!output_enable_n_o |-> write_strobe_n_o && data_low_lane_oe_n_o)
		else $error("read overlaps write or host drive");
	wr_oe_a: assert property (!write_strobe_n_o |-> output_enable_n_o && !data_low_lane_oe_n_o)
		else $error("write without data or with read enable");
	byte_hi_a: assert property (!bus_width_select_o |-> data_high_lane_oe_n_o)
		else $error("high lane driven in byte mode");
	byte_lsb_a: assert property (!bus_width_select_o && !chip_select_n_o |-> !data15_or_addr_lsb_oe_n_o)
		else $error("byte select pin not driven");
	rst_len_a: assert property ($rose(reset_unprotect_n_o) |-> int'(lo_q) >= pfh_pkg::RESET_PULSE_CYC)
		else $error("reset pulse too short");
	rst_quiet_a: assert property (wt_q |-> chip_select_n_o)
		else $error("access before ready after reset");
	wr_walk_a: assert property ($fell(write_strobe_n_o) |-> wr_s ##1 close_s)
		else $error("write cycle out of order");
	rd_walk_a: assert property ($fell(output_enable_n_o) |-> rd_s ##1 (output_enable_n_o && chip_select_n_o) ##1 close_s)
		else $error("read cycle out of order");
endmodule
bind pfh_host pfh_host_chk pfh_host_chk_i (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ack_o(ack_o), .chip_select_n_o(chip_select_n_o),
	.output_enable_n_o(output_enable_n_o), .write_strobe_n_o(write_strobe_n_o),
	.bus_width_select_o(bus_width_select_o), .reset_unprotect_n_o(reset_unprotect_n_o),
	.data_low_lane_oe_n_o(data_low_lane_oe_n_o), .data_high_lane_oe_n_o(data_high_lane_oe_n_o),
	.data15_or_addr_lsb_oe_n_o(data15_or_addr_lsb_oe_n_o), .ready_busy_n_i(ready_busy_n_i)
);

// *** test/pfh_host_bench.sv ***
// Self-checking bench for pfh_host with a behavioural flash on its pins.
// Assumes the flash model and the bound checker are compiled before it.
`timescale 1ns/1ps
module pfh_host_bench;
	typedef struct packed {
		logic        we; // Write
		logic        bm; // Byte mode
		logic        st; // Status read
		logic [17:0] a;  // Address
		logic [15:0] d;  // Write data or expected read
	} pfh_row_t;
	logic        sys_clk_i = 1'b0;                                 // Clock
	logic        rst_n = 1'b0, req = 1'b0, we = 1'b0, bm = 1'b0;   // Controls
	logic        st = 1'b0, hwr = 1'b0;                            // Status, reset request
	logic [17:0] addr = 18'h0_0000;                                // Address
	logic [15:0] wd = 16'h0000, rdata, md;                         // Data
	logic        ack, busy, frdy, cs_n, oe_n, ws_n, wsel, rp_n;    // Host outputs
	logic [16:0] pa;                                               // Address pins
	logic [7:0]  hlo;                                              // Host low lane
	logic [6:0]  hhi;                                              // Host high lane
	logic        h15, hlo_n, hhi_n, h15_n, mlo, mhi, mrb;          // Enables
	wire  [7:0]  dlo = !hlo_n ? hlo : (mlo ? md[7:0] : 8'hFF);     // Pulled-up lanes
	wire  [6:0]  dhi = !hhi_n ? hhi : (mhi ? md[14:8] : 7'h7F);
	wire         d15 = !h15_n ? h15 : (mhi ? md[15] : 1'b1);
	wire         rb = !mrb;                                        // Pulled-up ready line
	int          fails = 0, n_checks = 0, i, n;                    // Counters
	// Table: reads carry the expected value
	pfh_row_t rows [13] = '{'{1'b0, 1'b0, 1'b0, 18'h0_0010, 16'hFFFF}, '{1'b1, 1'b0, 1'b0, 18'h0_0010, 16'h1234},
		'{1'b0, 1'b0, 1'b0, 18'h0_0010, 16'h1234}, '{1'b1, 1'b1, 1'b0, 18'h0_0041, 16'h00AB},
		'{1'b1, 1'b1, 1'b0, 18'h0_0040, 16'h00CD}, '{1'b0, 1'b0, 1'b0, 18'h0_0020, 16'hABCD},
		'{1'b0, 1'b1, 1'b0, 18'h0_0021, 16'h0012}, '{1'b0, 1'b1, 1'b0, 18'h3_FFFF, 16'h00FF},
		'{1'b1, 1'b0, 1'b0, 18'h1_FFFF, 16'h8001}, '{1'b0, 1'b0, 1'b0, 18'h1_FFFF, 16'h8001},
		'{1'b0, 1'b0, 1'b1, 18'h0_0010, 16'h0034},
		'{1'b1, 1'b0, 1'b0, 18'h1_C000, 16'h0000}, '{1'b0, 1'b0, 1'b0, 18'h1_C000, 16'hFFFF}};
	always #(pfh_pkg::CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;
	pfh_host pfh_host_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n), .req_i(req), .we_i(we), .byte_mode_i(bm),
		.status_i(st), .addr_i(addr), .wdata_i(wd), .hw_reset_i(hwr), .ack_o(ack), .rdata_o(rdata),
		.busy_o(busy), .flash_ready_o(frdy), .addr_inputs_o(pa), .chip_select_n_o(cs_n),
		.output_enable_n_o(oe_n), .write_strobe_n_o(ws_n), .bus_width_select_o(wsel),
		.reset_unprotect_n_o(rp_n), .data_low_lane_i(dlo), .data_low_lane_o(hlo),
		.data_low_lane_oe_n_o(hlo_n), .data_high_lane_i(dhi), .data_high_lane_o(hhi),
		.data_high_lane_oe_n_o(hhi_n), .data15_or_addr_lsb_i(d15), .data15_or_addr_lsb_o(h15),
		.data15_or_addr_lsb_oe_n_o(h15_n), .ready_busy_n_i(rb));
	pfh_flash_model #(.PROT(7'h10)) pfh_flash_model_i (.cs_n_i(cs_n), .oe_n_i(oe_n), .ws_n_i(ws_n), .word_i(wsel),
		.rp_n_i(rp_n), .addr_i(pa), .d_i({d15, dhi, dlo}), .d_o(md), .lo_oe_o(mlo), .hi_oe_o(mhi), .rb_low_o(mrb));
	// Closing report and verdict
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Compare and count
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One access, request held until done
	task automatic access(input pfh_row_t r);
		int k;
		@(negedge sys_clk_i);
		{we, bm, st, addr, wd} = {r.we, r.bm, r.st, r.a, r.d};
		req = 1'b1;
		for (k = 0; k < 200 && ack !== 1'b1; k++) @(negedge sys_clk_i);
		if (ack !== 1'b1) begin
			fails++;
			end_sim();
		end
		req = 1'b0;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(negedge sys_clk_i);
		chk("pins in reset", {11'h000, ack, cs_n, oe_n, ws_n, rp_n}, 16'h000F);
		rst_n = 1'b1;
		for (i = 0; i < 20 && frdy !== 1'b1; i++) @(negedge sys_clk_i);
		chk("ready at start", {15'h0000, frdy}, 16'h0001);
		chk("idle at start", {15'h0000, busy}, 16'h0000);
		$display("test start done");
		for (i = 0; i < 13; i++) begin
			access(rows[i]);
			if (!rows[i].we) chk("read data", rdata, rows[i].d);
		end
		$display("test table done");
		// Write then the ready line falls
		access('{1'b1, 1'b0, 1'b0, 18'h0_0100, 16'h5A5A});
		for (i = 0; i < 8 && frdy !== 1'b0; i++) @(negedge sys_clk_i);
		chk("busy after write", {15'h0000, frdy}, 16'h0000);
		// Hardware reset in mid busy: pulse length, ready held low
		hwr = 1'b1;
		@(negedge sys_clk_i);
		hwr = 1'b0;
		chk("busy in reset", {15'h0000, busy}, 16'h0001);
		n = 0;
		for (i = 0; i < 40 && !(n > 0 && rp_n === 1'b1); i++) begin
			@(negedge sys_clk_i);
			if (rp_n === 1'b0) n++;
		end
		chk("reset length", n[15:0], 16'(pfh_pkg::RESET_PULSE_CYC));
		chk("ready low after reset", {15'h0000, rb}, 16'h0000);
		for (i = 0; i < 40 && frdy !== 1'b1; i++) @(negedge sys_clk_i);
		chk("ready back", {15'h0000, frdy}, 16'h0001);
		access('{1'b0, 1'b0, 1'b0, 18'h0_0100, 16'h0000});
		chk("data kept", rdata, 16'h5A5A);
		$display("test reset done");
		end_sim();
	end
endmodule
